// File: sfp_pkg.sv
package sfp_pkg;
	// ------------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------------
	localparam logic [7:0] CMD_LATCH_SET    = 8'h06;
	localparam logic [7:0] CMD_LATCH_CLEAR  = 8'h04;
	localparam logic [7:0] CMD_STATUS_READ  = 8'h05;
	localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
	localparam logic [7:0] CMD_MEM_READ     = 8'h03;
	localparam logic [7:0] CMD_FAST_READ    = 8'h0B;
	localparam logic [7:0] CMD_MEM_WRITE    = 8'h02;
	// ------------------------------------------------------------------
	// Status byte layout
	// ------------------------------------------------------------------
	localparam int         ST_PIN_EN_BIT  = 7;
	localparam int         ST_BP_HI_BIT   = 3;
	localparam int         ST_BP_LO_BIT   = 2;
	localparam int         ST_LATCH_BIT   = 1;
	localparam logic [7:0] ST_WRITE_MASK  = 8'h8C;
	localparam logic [1:0] BP_RESET       = 2'h0;
	// ------------------------------------------------------------------
	// Array and protection ranges
	// ------------------------------------------------------------------
	localparam int          ADDR_W        = 15;
	localparam logic [14:0] ADDR_QUARTER  = 15'h6000;
	localparam logic [14:0] ADDR_HALF     = 15'h4000;
	localparam logic [2:0]  BIT_LAST      = 3'h7;
	// ------------------------------------------------------------------
	// Host register map (Avalon word addresses)
	// ------------------------------------------------------------------
	localparam logic [1:0] REG_CTRL   = 2'h0;
	localparam logic [1:0] REG_TXDATA = 2'h1;
	localparam logic [1:0] REG_RXDATA = 2'h2;
	localparam logic [1:0] REG_STAT   = 2'h3;
	localparam int         CTRL_SEL_BIT  = 0;
	localparam int         CTRL_WP_BIT   = 1;
	localparam logic [7:0] CLK_DIV_HALF  = 8'h04;
endpackage : sfp_pkg

// File: sfp_link_if.sv
`timescale 1ns/10ps
interface sfp_link_if;
	logic select_n;
	logic sclk;
	logic mosi;
	logic miso;
	logic miso_oe_n;
	logic wp_n;
	modport device (input select_n, input sclk, input mosi, input wp_n,
		output miso, output miso_oe_n);
	modport host (output select_n, output sclk, output mosi, output wp_n,
		input miso, input miso_oe_n);
endinterface : sfp_link_if

// File: sfp_device.sv
`timescale 1ns/10ps
// Contract
// - Status bits 7,3,2,1 live; others zero
// - Latch set by set command; cleared by clear command, accepted status write or write end
// - Block-protect bits are nonvolatile; here reset loads them with BP_RESET
// - Protect pair selects none, quarter, half, all
// - Memory write needs latch and unprotected address
// - Pin ignored when pin-enable is zero
// - Status write refused by pin or latch
// - Write: latch set, command, two address bytes
// - Address increments per byte, wraps at top
// - Each byte stored after eighth bit
// - Select rise ends write, drops partial byte
// - Protect pin sampled at select fall
// - Read: command, address, then input ignored
// - Read data MSB first, eight clocks
// - Select rise ends read, output released
// - Fast read has one dummy byte
// - Fast read otherwise matches read
// - Command codes as listed
// - Completed write clears latch
// - Sample on rising, drive on falling, MSB first
// - Only first byte decoded as command
module sfp_device
	import sfp_pkg::*;
#(
	parameter int DEPTH = 32768
) (
	input  wire logic  i_clock,
	input  wire logic  i_rst_b,
	sfp_link_if.device link,
	output logic [7:0] o_status
);
	typedef enum logic [6:0] {
		SFP_CMD   = 7'b0000001,
		SFP_ADDR1 = 7'b0000010,
		SFP_ADDR0 = 7'b0000100,
		SFP_DUMMY = 7'b0001000,
		SFP_WDATA = 7'b0010000,
		SFP_RDATA = 7'b0100000,
		SFP_IDLE  = 7'b1000000
	} sfp_dstate_t;
	// ------------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------------
	logic [2:0] sel_sync_reg, clk_sync_reg;
	logic [1:0] mosi_sync_reg, wp_sync_reg;
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sel_sync_reg  <= 3'h7;
			clk_sync_reg  <= 3'h0;
			mosi_sync_reg <= 2'h0;
			wp_sync_reg   <= 2'h3;
		end else begin
			sel_sync_reg  <= {sel_sync_reg[1:0], link.select_n};
			clk_sync_reg  <= {clk_sync_reg[1:0], link.sclk};
			mosi_sync_reg <= {mosi_sync_reg[0], link.mosi};
			wp_sync_reg   <= {wp_sync_reg[0], link.wp_n};
		end
	end
	wire sel_n    = sel_sync_reg[1];
	wire sel_fall = sel_sync_reg[2] & ~sel_sync_reg[1];
	wire sclk_r   = ~clk_sync_reg[2] & clk_sync_reg[1] & ~sel_n;
	wire sclk_f   = clk_sync_reg[2] & ~clk_sync_reg[1] & ~sel_n;
	wire din      = mosi_sync_reg[1];
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [7:0]        mem [DEPTH];
	sfp_dstate_t       state_reg;
	logic [7:0]        cmd_reg, shift_reg, out_reg;
	logic [2:0]        bit_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic              latch_reg, pin_en_reg, wp_held_reg, oe_n_reg, miso_reg;
	logic [1:0]        bp_reg;
	wire [7:0] in_byte   = {shift_reg[6:0], din};
	wire       byte_done = sclk_r && (bit_reg == BIT_LAST);
	wire [7:0] status = {pin_en_reg, 3'h0, bp_reg, latch_reg, 1'b0};
	// Protection decode
	wire in_prot = (bp_reg == 2'h3) ||
		(bp_reg == 2'h2 && addr_reg >= ADDR_HALF) ||
		(bp_reg == 2'h1 && addr_reg >= ADDR_QUARTER);
	wire mem_we  = byte_done && state_reg == SFP_WDATA
		&& cmd_reg == CMD_MEM_WRITE && latch_reg && !in_prot;
	wire st_ok   = latch_reg && !(pin_en_reg && !wp_held_reg);
	wire st_we   = byte_done && state_reg == SFP_WDATA
		&& cmd_reg == CMD_STATUS_WRITE && st_ok;
	wire is_read = (cmd_reg == CMD_MEM_READ) || (cmd_reg == CMD_FAST_READ);
	// A memory write completes when select rises in its data phase
	wire write_end = sel_n && state_reg == SFP_WDATA && cmd_reg == CMD_MEM_WRITE;
	wire [ADDR_W-1:0] addr_inc = addr_reg + 1'b1;
	// ------------------------------------------------------------------
	// Bit counter and shifter
	// ------------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bit_reg   <= 3'h0;
			shift_reg <= 8'h00;
		end else if (sel_fall) begin
			bit_reg   <= 3'h0;
			shift_reg <= 8'h00;
		end else if (sclk_r) begin
			bit_reg   <= bit_reg + 3'h1;
			shift_reg <= in_byte;
		end
	end
	// ------------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg   <= SFP_IDLE;
			cmd_reg     <= 8'h00;
			addr_reg    <= '0;
			latch_reg   <= 1'b0;
			pin_en_reg  <= 1'b0;
			bp_reg      <= BP_RESET;
			wp_held_reg <= 1'b1;
		end else if (sel_n) begin
			if (write_end) begin
				latch_reg <= 1'b0;
			end
			state_reg <= SFP_IDLE;
		end else if (sel_fall) begin
			state_reg   <= SFP_CMD;
			wp_held_reg <= wp_sync_reg[1];
		end else if (byte_done) begin
			case (state_reg)
				SFP_CMD: begin
					cmd_reg <= in_byte;
					case (in_byte)
						CMD_LATCH_SET: begin
							latch_reg <= 1'b1;
							state_reg <= SFP_IDLE;
						end
						CMD_LATCH_CLEAR: begin
							latch_reg <= 1'b0;
							state_reg <= SFP_IDLE;
						end
						CMD_STATUS_READ:  state_reg <= SFP_RDATA;
						CMD_STATUS_WRITE: state_reg <= SFP_WDATA;
						CMD_MEM_READ, CMD_FAST_READ, CMD_MEM_WRITE: state_reg <= SFP_ADDR1;
						default: state_reg <= SFP_IDLE;
					endcase
				end
				SFP_ADDR1: begin
					addr_reg[14:8] <= in_byte[6:0];
					state_reg      <= SFP_ADDR0;
				end
				SFP_ADDR0: begin
					addr_reg[7:0] <= in_byte;
					if (cmd_reg == CMD_FAST_READ) begin
						state_reg <= SFP_DUMMY;
					end else if (cmd_reg == CMD_MEM_WRITE) begin
						state_reg <= SFP_WDATA;
					end else begin
						state_reg <= SFP_RDATA;
					end
				end
				SFP_DUMMY: state_reg <= SFP_RDATA;
				SFP_WDATA: begin
					if (cmd_reg == CMD_STATUS_WRITE) begin
						if (st_we) begin
							pin_en_reg <= in_byte[ST_PIN_EN_BIT];
							bp_reg     <= {in_byte[ST_BP_HI_BIT], in_byte[ST_BP_LO_BIT]};
							latch_reg  <= 1'b0;
						end
						state_reg <= SFP_IDLE;
					end else begin
						addr_reg <= addr_inc;
					end
				end
				SFP_RDATA: begin
					if (is_read) begin
						addr_reg <= addr_inc;
					end
				end
				SFP_IDLE: state_reg <= SFP_IDLE;
				default: state_reg <= SFP_IDLE;
			endcase
		end
	end
	// ------------------------------------------------------------------
	// Array write
	// ------------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (mem_we) begin
			mem[addr_reg] <= in_byte;
		end
	end
	// ------------------------------------------------------------------
	// Output shifter, driven on falling serial edge
	// ------------------------------------------------------------------
	wire [7:0] load_byte = is_read ? mem[addr_reg] : status;
	wire       rd_active = state_reg == SFP_RDATA;
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			out_reg  <= 8'h00;
			miso_reg <= 1'b0;
			oe_n_reg <= 1'b1;
		end else if (sel_n) begin
			oe_n_reg <= 1'b1;
		end else if (sclk_f && rd_active) begin
			oe_n_reg <= 1'b0;
			if (bit_reg == 3'h0) begin
				miso_reg <= load_byte[7];
				out_reg  <= {load_byte[6:0], 1'b0};
			end else begin
				miso_reg <= out_reg[7];
				out_reg  <= {out_reg[6:0], 1'b0};
			end
		end
	end
	assign link.miso      = miso_reg;
	assign link.miso_oe_n = oe_n_reg;
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_status <= 8'h00;
		end else begin
			o_status <= status;
		end
	end
endmodule : sfp_device

// File: sfp_host.sv
`timescale 1ns/10ps
module sfp_host
	import sfp_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	input  wire logic [1:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	sfp_link_if.host         link
);
	typedef enum logic [1:0] {
		SFH_IDLE = 2'b01,
		SFH_XFER = 2'b10
	} sfh_state_t;
	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	sfh_state_t state_reg;
	logic       sel_n_reg, wp_n_reg, sclk_reg;
	logic [7:0] div_reg, tx_reg, rx_reg;
	logic [3:0] half_reg;
	logic [1:0] miso_sync_reg;
	logic       ack_reg;
	wire busy    = state_reg == SFH_XFER;
	wire wr_ctrl = i_avs_write && i_avs_address == REG_CTRL;
	wire wr_tx   = i_avs_write && i_avs_address == REG_TXDATA && !busy;
	wire tick    = busy && div_reg == CLK_DIV_HALF;
	// Write to data register stalls while a byte is in flight
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;
	wire [31:0] rd_mux =
		(i_avs_address == REG_CTRL)   ? {30'h0, wp_n_reg, ~sel_n_reg} :
		(i_avs_address == REG_RXDATA) ? {24'h0, rx_reg} :
		(i_avs_address == REG_STAT)   ? {31'h0, busy} : 32'h0;
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ack_reg        <= 1'b0;
			o_avs_readdata <= 32'h0;
		end else begin
			ack_reg        <= (i_avs_read || (i_avs_write && (!busy || wr_ctrl))) && !ack_reg;
			o_avs_readdata <= rd_mux;
		end
	end
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			miso_sync_reg <= 2'h0;
		end else begin
			miso_sync_reg <= {miso_sync_reg[0], link.miso};
		end
	end
	// ------------------------------------------------------------------
	// Byte engine, mode 0, MSB first
	// ------------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= SFH_IDLE;
			sel_n_reg <= 1'b1;
			wp_n_reg  <= 1'b1;
			sclk_reg  <= 1'b0;
			div_reg   <= 8'h00;
			half_reg  <= 4'h0;
			tx_reg    <= 8'h00;
			rx_reg    <= 8'h00;
		end else begin
			if (wr_ctrl && ack_reg) begin
				sel_n_reg <= ~i_avs_writedata[CTRL_SEL_BIT];
				wp_n_reg  <= i_avs_writedata[CTRL_WP_BIT];
			end
			case (state_reg)
				SFH_IDLE: begin
					if (wr_tx && ack_reg) begin
						tx_reg    <= i_avs_writedata[7:0];
						div_reg   <= 8'h00;
						half_reg  <= 4'h0;
						state_reg <= SFH_XFER;
					end
				end
				SFH_XFER: begin
					div_reg <= tick ? 8'h00 : div_reg + 8'h01;
					if (tick) begin
						sclk_reg <= ~sclk_reg;
						half_reg <= half_reg + 4'h1;
						// Sample at the end of the high phase: sync and device latency
						// keep miso several clocks behind the falling edge
						if (sclk_reg) begin
							rx_reg <= {rx_reg[6:0], miso_sync_reg[1]};
							tx_reg <= {tx_reg[6:0], 1'b0};
						end
						if (half_reg == 4'hF) begin
							state_reg <= SFH_IDLE;
						end
					end
				end
				default: state_reg <= SFH_IDLE;
			endcase
		end
	end
	assign link.select_n = sel_n_reg;
	assign link.sclk     = sclk_reg;
	assign link.mosi     = tx_reg[7];
	assign link.wp_n     = wp_n_reg;
endmodule : sfp_host

// File: sfp_assertions.sv
`timescale 1ns/10ps
module sfp_assertions (
	input wire logic       i_clock,
	input wire logic       i_rst_b,
	input wire logic       select_n,
	input wire logic       sclk,
	input wire logic       mosi,
	input wire logic       miso,
	input wire logic       miso_oe_n,
	input wire logic       wp_n,
	input wire logic [7:0] o_status
);
	// ------------------------------------------------------------------
	// Link and status checks
	// ------------------------------------------------------------------
	// Pin lock seen at select fall holds for the whole select period
	logic sel_q_reg;
	logic lock_reg;
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sel_q_reg <= 1'b1;
			lock_reg  <= 1'b0;
		end else begin
			sel_q_reg <= select_n;
			if (select_n) begin
				lock_reg <= 1'b0;
			end else if (sel_q_reg && !wp_n && o_status[7]) begin
				lock_reg <= 1'b1;
			end
		end
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	a_out_release: assert property ($rose(select_n) |-> ##[0:6] miso_oe_n)
		else $error("output still driven after deselect");
	a_idle_no_drive: assert property (select_n [*8] |-> miso_oe_n)
		else $error("output driven while idle");
	a_idle_status: assert property (select_n [*8] |=> $stable(o_status))
		else $error("status changed while idle");
	a_status_zero: assert property (o_status[6:4] == 3'h0 && !o_status[0])
		else $error("fixed status bits not zero");
	a_mosi_change: assert property ($changed(mosi) |-> !sclk)
		else $error("data in changed while clock high");
	a_miso_change: assert property (!miso_oe_n && $past(!miso_oe_n) && $changed(miso) |-> !sclk)
		else $error("data out changed while clock high");
	a_sclk_high: assert property ($rose(sclk) |-> sclk [*5] ##1 !sclk)
		else $error("serial clock high phase wrong");
	a_sel_clk_low: assert property ($fell(select_n) |-> !sclk ##1 !sclk)
		else $error("clock not low at select");
	a_status_lock: assert property (lock_reg && !select_n |=> $stable(o_status[7:2]))
		else $error("locked status changed");
endmodule : sfp_assertions

// File: tb.sv
`timescale 1ns/10ps
module tb import sfp_pkg::*;;
	localparam logic [14:0] PROBE [4] = '{15'h3FFF, 15'h4000, 15'h5FFF, 15'h6000};
	logic        i_clock;
	logic        i_rst_b;
	logic [1:0]  address;
	logic        rd;
	logic        wr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] rq;
	logic        wait_req;
	logic [7:0]  status;
	logic [7:0]  rx;
	logic [7:0]  mem [4];
	logic        wp;
	logic        prot;
	int          fails = 0;
	int          tests_run = 0;
	int          cycles = 0;
	sfp_link_if sfp_link_if_i ();
	sfp_device sfp_device_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .link(sfp_link_if_i),
		.o_status(status));
	sfp_host sfp_host_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_avs_address(address),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wait_req), .link(sfp_link_if_i));
	sfp_assertions sfp_assertions_i (.i_clock(i_clock), .i_rst_b(i_rst_b),
		.select_n(sfp_link_if_i.select_n), .sclk(sfp_link_if_i.sclk),
		.mosi(sfp_link_if_i.mosi), .miso(sfp_link_if_i.miso),
		.miso_oe_n(sfp_link_if_i.miso_oe_n), .wp_n(sfp_link_if_i.wp_n), .o_status(status));
	// ------------------------------------------------------------------
	// Clock and watchdog
	// ------------------------------------------------------------------
	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 50000) begin
			fails = fails + 1;
			complete_run();
		end
	end
	// ------------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------------
	// Request held until the rising edge that samples waitrequest low
	task automatic av(input logic w, input logic [1:0] a, input logic [31:0] d);
		@(posedge i_clock);
		address <= a;
		rd <= !w;
		wr <= w;
		wdata <= d;
		do begin
			@(posedge i_clock);
		end while (wait_req !== 1'b0);
		rq = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : av
	task automatic sel(input logic s);
		av(1'b1, REG_CTRL, {30'h0, wp, s});
	endtask : sel
	task automatic xfer(input logic [7:0] t);
		av(1'b1, REG_TXDATA, {24'h0, t});
		do av(1'b0, REG_STAT, 32'h0); while (rq[0] !== 1'b0);
		av(1'b0, REG_RXDATA, 32'h0);
		rx = rq[7:0];
	endtask : xfer
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic cmd(input logic [7:0] c);
		sel(1'b1);
		xfer(c);
		sel(1'b0);
	endtask : cmd
	task automatic st_chk(input logic [7:0] exp);
		sel(1'b1);
		xfer(CMD_STATUS_READ);
		xfer(8'h00);
		sel(1'b0);
		check(rx, exp);
		check(status, exp);
	endtask : st_chk
	task automatic status_write_cmd(input logic l, input logic [7:0] d);
		if (l) cmd(CMD_LATCH_SET);
		sel(1'b1);
		xfer(CMD_STATUS_WRITE);
		xfer(d);
		sel(1'b0);
	endtask : status_write_cmd
	task automatic mwr(input logic [14:0] a, input logic [7:0] d);
		cmd(CMD_LATCH_SET);
		sel(1'b1);
		xfer(CMD_MEM_WRITE);
		xfer({1'b1, a[14:8]});
		xfer(a[7:0]);
		xfer(d);
		sel(1'b0);
	endtask : mwr
	// Data phase sends command codes that the device must ignore
	task automatic mrd(input logic [7:0] c, input logic [14:0] a, input logic [7:0] e0,
		input logic [7:0] e1, input logic two);
		sel(1'b1);
		xfer(c);
		xfer({1'b0, a[14:8]});
		xfer(a[7:0]);
		if (c == CMD_FAST_READ) xfer(8'hFF);
		xfer(CMD_LATCH_SET);
		check(rx, e0);
		if (two) xfer(CMD_STATUS_WRITE);
		if (two) check(rx, e1);
		sel(1'b0);
	endtask : mrd
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	// ------------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------------
	initial begin
		i_rst_b = 1'b0;
		address = 2'h0;
		rd = 1'b0;
		wr = 1'b0;
		wdata = 32'h0;
		wp = 1'b1;
		repeat (3) @(posedge i_clock);
		i_rst_b <= 1'b1;
		st_chk(8'h00);
		status_write_cmd(1'b0, 8'hFF);
		st_chk(8'h00);
		cmd(CMD_LATCH_SET);
		st_chk(8'h02);
		cmd(CMD_LATCH_CLEAR);
		st_chk(8'h00);
		status_write_cmd(1'b1, 8'hF5);
		st_chk(8'h84);
		$display("test status finished");
		wp = 1'b0;
		status_write_cmd(1'b1, 8'h00);
		st_chk(8'h86);
		wp = 1'b1;
		sel(1'b1);
		xfer(CMD_STATUS_WRITE);
		wp = 1'b0;
		sel(1'b1);
		xfer(8'h08);
		sel(1'b0);
		st_chk(8'h08);
		status_write_cmd(1'b1, 8'h00);
		st_chk(8'h00);
		wp = 1'b1;
		$display("test pin finished");
		mwr(15'h7FFF, 8'h3C);
		st_chk(8'h00);
		mwr(15'h0000, 8'hC3);
		mrd(CMD_MEM_READ, 15'h7FFF, 8'h3C, 8'hC3, 1'b1);
		mrd(CMD_FAST_READ, 15'h7FFF, 8'h3C, 8'hC3, 1'b1);
		st_chk(8'h00);
		// Two data bytes in one select period both land
		cmd(CMD_LATCH_SET);
		sel(1'b1);
		xfer(CMD_MEM_WRITE);
		xfer(8'h00);
		xfer(8'h10);
		xfer(8'h5A);
		xfer(8'hA5);
		sel(1'b0);
		st_chk(8'h00);
		mrd(CMD_MEM_READ, 15'h0010, 8'h5A, 8'hA5, 1'b1);
		$display("test stream finished");
		for (int b = 0; b < 4; b++) begin
			status_write_cmd(1'b1, {4'h0, b[1:0], 2'h0});
			for (int i = 0; i < 4; i++) begin
				prot = (b == 3) || (b == 2 && PROBE[i] >= ADDR_HALF)
					|| (b == 1 && PROBE[i] >= ADDR_QUARTER);
				if (!prot) mem[i] = {b[3:0], i[3:0]};
				mwr(PROBE[i], {b[3:0], i[3:0]});
				mrd(CMD_MEM_READ, PROBE[i], mem[i], 8'h00, 1'b0);
			end
		end
		$display("test protect finished");
		complete_run();
	end
endmodule : tb
